// ===== ccrop_pkg.sv
// package: constants, types and register map of the compare and control register ops block
package ccrop_pkg;

    // word width of operands and special registers
    localparam int unsigned DW          = 32;
    localparam int unsigned AW          = 8;
    localparam int unsigned IMM_W       = 7;

    // register byte offsets on the wishbone slave
    localparam logic [7:0]  OFS_SRC1    = 8'h00;
    localparam logic [7:0]  OFS_SRC2    = 8'h04;
    localparam logic [7:0]  OFS_GUARD   = 8'h08;
    localparam logic [7:0]  OFS_OP      = 8'h0C;
    localparam logic [7:0]  OFS_RESULT  = 8'h10;
    localparam logic [7:0]  OFS_RPC     = 8'h14;
    localparam logic [7:0]  OFS_CSW     = 8'h18;
    localparam logic [7:0]  OFS_EXCVIEW = 8'h1C;
    localparam logic [7:0]  OFS_STATUS  = 8'h20;

    // operation register fields
    localparam int unsigned OP_CODE_LSB  = 0;
    localparam int unsigned OP_GUARD_BIT = 4;
    localparam int unsigned OP_IMM_LSB   = 8;

    // values after reset
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;
    localparam logic [31:0] RST_CSW     = 32'h0000_0000;

    // bits of the status word that are exception flags or enables
    localparam logic [31:0] EXC_BITS    = 32'hFFFF_00FF;

    // delay from status word update to interrupt logic, in cycles
    localparam int unsigned EXC_DELAY   = 3;

    // operation codes
    typedef enum logic [1:0] {
        CCROP_NEQ   = 2'h0,
        CCROP_NEQI  = 2'h1,
        CCROP_WRPC  = 2'h2,
        CCROP_WCSW  = 2'h3
    } ccrop_opc_t;

    // decoded operation request
    typedef struct packed {
        logic [IMM_W-1:0] imm;
        logic             use_guard;
        ccrop_opc_t       opc;
    } ccrop_op_t;

    // hardware update of the status word from the core
    typedef struct packed {
        logic [DW-1:0] mask;
        logic [DW-1:0] value;
    } ccrop_hwcsw_t;

    // interruptible jump update of the resume pointer
    typedef struct packed {
        logic          valid;
        logic [DW-1:0] target;
    } ccrop_jump_t;

endpackage : ccrop_pkg

// ===== ccrop_delay.sv
// fixed-depth register pipeline delaying a word by a number of cycles
`timescale 1ns/1ns
`default_nettype none
module ccrop_delay #(
    parameter int unsigned DEPTH = ccrop_pkg::EXC_DELAY,
    parameter int unsigned W     = ccrop_pkg::DW
) (
    input  wire logic         CLK,
    input  wire logic         RST,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] stage_ff [DEPTH];

    // shift chain; last stage is the registered output
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < DEPTH; i++) stage_ff[i] <= '0;
        end else begin
            stage_ff[0] <= din;
            for (int i = 1; i < DEPTH; i++) stage_ff[i] <= stage_ff[i-1];
        end
    end

    assign dout = stage_ff[DEPTH-1];

endmodule : ccrop_delay
`default_nettype wire

// ===== ccrop_top.sv
// compare and special register write operations behind a wishbone slave
`timescale 1ns/1ns
`default_nettype none
module ccrop_top (
    input  wire logic                   CLK,
    input  wire logic                   RST,
    // wishbone classic slave
    input  wire logic                   WB_CYC_I,
    input  wire logic                   WB_STB_I,
    input  wire logic                   WB_WE_I,
    input  wire logic [7:0]             WB_ADR_I,
    input  wire logic [3:0]             WB_SEL_I,
    input  wire logic [31:0]            WB_DAT_I,
    output logic      [31:0]            WB_DAT_O,
    output logic                        WB_ACK_O,
    // core-side hardware updates, same clock
    input  wire ccrop_pkg::ccrop_jump_t  JUMP_I,
    input  wire ccrop_pkg::ccrop_hwcsw_t HW_CSW_I,
    // special registers as seen by the core
    output logic      [31:0]            RESUME_PROGRAM_COUNTER,
    output logic      [31:0]            CONTROL_STATUS_WORD,
    output logic      [31:0]            EXC_VIEW,
    output logic                        OP_DONE
);

    // bus handshake states
    typedef enum logic [1:0] {
        CCROP_IDLE = 2'b01,
        CCROP_ACK  = 2'b10
    } ccrop_bus_t;

    ccrop_bus_t           bus_ff;
    ccrop_bus_t           nxt_bus;

    // operand and special registers
    logic [31:0]          first_source_ff;
    logic [31:0]          second_source_ff;
    logic [31:0]          guard_ff;
    logic [31:0]          op_word_ff;
    logic [31:0]          result_ff;
    logic [31:0]          rpc_ff;
    logic [31:0]          csw_ff;
    logic [31:0]          dat_o_ff;
    logic                 done_ff;
    logic [31:0]          op_count_ff;

    // combinational next values and views
    logic [31:0]          nxt_result;
    logic [31:0]          nxt_rpc;
    logic [31:0]          nxt_csw;
    logic [31:0]          exc_view;
    logic [31:0]          rd_data;

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge_sel(
        input logic [31:0] old_w,
        input logic [31:0] new_w,
        input logic [3:0]  sel
    );
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old_w & ~m) | (new_w & m);
    endfunction : merge_sel

    // not-equal as a result word: one in bit zero, zeros above
    function automatic logic [31:0] neq_word(
        input logic [31:0] a,
        input logic [31:0] b
    );
        return {31'h0, (a != b)};
    endfunction : neq_word

    // --------------------------------------------------------------
    // bus decode
    // --------------------------------------------------------------

    // request seen in idle; the write takes effect at the ack edge
    wire        req      = WB_CYC_I & WB_STB_I;
    wire        take     = req & (bus_ff == CCROP_IDLE);
    wire        wr_fire  = req & WB_WE_I & (bus_ff == CCROP_ACK);

    // address decode, one hit per mapped word
    wire        hit_src1  = (WB_ADR_I == ccrop_pkg::OFS_SRC1);
    wire        hit_src2  = (WB_ADR_I == ccrop_pkg::OFS_SRC2);
    wire        hit_guard = (WB_ADR_I == ccrop_pkg::OFS_GUARD);
    wire        hit_op    = (WB_ADR_I == ccrop_pkg::OFS_OP);
    wire        hit_res   = (WB_ADR_I == ccrop_pkg::OFS_RESULT);
    wire        hit_rpc   = (WB_ADR_I == ccrop_pkg::OFS_RPC);
    wire        hit_csw   = (WB_ADR_I == ccrop_pkg::OFS_CSW);
    wire        hit_excv  = (WB_ADR_I == ccrop_pkg::OFS_EXCVIEW);
    wire        hit_stat  = (WB_ADR_I == ccrop_pkg::OFS_STATUS);

    // operand write strobes; read-only words have none, so a
    // software write to a result or special register is dropped
    wire        wr_src1   = wr_fire & hit_src1;
    wire        wr_src2   = wr_fire & hit_src2;
    wire        wr_guard  = wr_fire & hit_guard;

    // the op register issues only on a full word write
    wire        issue     = wr_fire & hit_op & (WB_SEL_I == 4'hF);

    // decoded operation from the written word
    ccrop_pkg::ccrop_op_t op;
    assign op.opc       = ccrop_pkg::ccrop_opc_t'(WB_DAT_I[ccrop_pkg::OP_CODE_LSB +: 2]);
    assign op.use_guard = WB_DAT_I[ccrop_pkg::OP_GUARD_BIT];
    assign op.imm       = WB_DAT_I[ccrop_pkg::OP_IMM_LSB +: ccrop_pkg::IMM_W];

    // a clear guard bit skips the op, but the op word is still
    // recorded so software can read back what it issued;
    // missing guard behaves as a true guard
    wire        guard_ok  = ~op.use_guard | guard_ff[0];
    wire        exec      = issue & guard_ok;

    wire        do_neq    = exec & (op.opc == ccrop_pkg::CCROP_NEQ);
    wire        do_neqi   = exec & (op.opc == ccrop_pkg::CCROP_NEQI);
    wire        do_wrpc   = exec & (op.opc == ccrop_pkg::CCROP_WRPC);
    wire        do_wcsw   = exec & (op.opc == ccrop_pkg::CCROP_WCSW);

    // --------------------------------------------------------------
    // compare results
    // --------------------------------------------------------------

    // register compare, any differing bit gives one
    wire [31:0] neq_reg  = neq_word(first_source_ff, second_source_ff);
    // immediate zero-extended, both sides unsigned; a seven bit
    // field carries no sign, so no extension choice arises
    wire [31:0] imm_ext  = {25'h0, op.imm};
    wire [31:0] neq_imm  = neq_word(first_source_ff, imm_ext);

    // result keeps its value unless a compare really executes
    assign nxt_result = do_neq  ? neq_reg :
                        do_neqi ? neq_imm :
                        result_ff;

    // --------------------------------------------------------------
    // resume pointer
    // --------------------------------------------------------------

    // jump updates land in any cycle valid is high, even while a
    // bus access is still waiting for its ack;
    // software write listed first so it wins over a coinciding jump
    assign nxt_rpc = do_wrpc      ? first_source_ff :
                     JUMP_I.valid ? JUMP_I.target :
                     rpc_ff;

    // --------------------------------------------------------------
    // control and status word
    // --------------------------------------------------------------

    // software mask is the second source; empty when not executing
    wire [31:0] sw_mask = do_wcsw ? second_source_ff : 32'h0000_0000;
    // a hardware mask held high keeps forcing its bits every cycle
    wire [31:0] hw_mask = HW_CSW_I.mask;

    // hardware bits first, then software-masked bits, rest kept;
    // sticky record bits stay until software clears them here
    assign nxt_csw = (HW_CSW_I.value  & hw_mask) |
                     (first_source_ff & sw_mask & ~hw_mask) |
                     (csw_ff          & ~sw_mask & ~hw_mask);

    // only flag and enable bits travel to the interrupt side
    wire [31:0] csw_exc = csw_ff & ccrop_pkg::EXC_BITS;

    // exception flags and enables seen late by interrupt logic;
    // software must leave slack before an interruptible jump,
    // the hardware does not stall a jump that comes too soon
    ccrop_delay #(
        .DEPTH (ccrop_pkg::EXC_DELAY),
        .W     (ccrop_pkg::DW)
    ) u_exc_delay (
        .CLK  (CLK),
        .RST  (RST),
        .din  (csw_exc),
        .dout (exc_view)
    );

    // --------------------------------------------------------------
    // read mux
    // --------------------------------------------------------------

    // unmapped addresses read as zero and still get an ack;
    // the exception view is the delayed copy, not the live word
    assign rd_data = hit_src1  ? first_source_ff  :
                     hit_src2  ? second_source_ff :
                     hit_guard ? guard_ff         :
                     hit_op    ? op_word_ff       :
                     hit_res   ? result_ff        :
                     hit_rpc   ? rpc_ff           :
                     hit_csw   ? csw_ff           :
                     hit_excv  ? exc_view         :
                     hit_stat  ? op_count_ff      :
                     32'h0000_0000;

    // --------------------------------------------------------------
    // bus state machine
    // --------------------------------------------------------------

    // one fixed wait state; the ack state always returns to idle,
    // so two acks can never follow each other;
    // ack one cycle after the request, dropped the cycle after
    always_comb begin
        nxt_bus = bus_ff;
        unique case (bus_ff)
            CCROP_IDLE: begin
                if (take) nxt_bus = CCROP_ACK;
            end
            CCROP_ACK: begin
                nxt_bus = CCROP_IDLE;
            end
            default: begin
                nxt_bus = CCROP_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bus_ff   <= CCROP_IDLE;
            dat_o_ff <= ccrop_pkg::RST_WORD;
        end else begin
            bus_ff   <= nxt_bus;
            // read data registered together with the ack
            if (take) dat_o_ff <= rd_data;
        end
    end

    // --------------------------------------------------------------
    // operand registers
    // --------------------------------------------------------------

    // first source; partial writes keep the other bytes
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            first_source_ff <= ccrop_pkg::RST_WORD;
        end else if (wr_src1) begin
            first_source_ff <= merge_sel(first_source_ff, WB_DAT_I, WB_SEL_I);
        end
    end

    // second source, also the mask of a status word write
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            second_source_ff <= ccrop_pkg::RST_WORD;
        end else if (wr_src2) begin
            second_source_ff <= merge_sel(second_source_ff, WB_DAT_I, WB_SEL_I);
        end
    end

    // guard word; only bit zero steers execution
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            guard_ff <= ccrop_pkg::RST_WORD;
        end else if (wr_guard) begin
            guard_ff <= merge_sel(guard_ff, WB_DAT_I, WB_SEL_I);
        end
    end

    // --------------------------------------------------------------
    // operation issue and special registers
    // --------------------------------------------------------------

    // op word keeps the last issued command, skipped ones included
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            op_word_ff <= ccrop_pkg::RST_WORD;
        end else if (issue) begin
            op_word_ff <= WB_DAT_I;
        end
    end

    // executed op count; a failed guard does not count
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            op_count_ff <= ccrop_pkg::RST_WORD;
        end else if (exec) begin
            op_count_ff <= op_count_ff + 32'h0000_0001;
        end
    end

    // done pulse one cycle after an executed operation
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= exec;
        end
    end

    // compare result; only an executed compare changes it
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            result_ff <= ccrop_pkg::RST_WORD;
        end else begin
            result_ff <= nxt_result;
        end
    end

    // resume pointer; software write or jump, else held
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rpc_ff <= ccrop_pkg::RST_WORD;
        end else begin
            rpc_ff <= nxt_rpc;
        end
    end

    // status word; the new value shows the very next cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            csw_ff <= ccrop_pkg::RST_CSW;
        end else begin
            csw_ff <= nxt_csw;
        end
    end

    // outputs straight from flops; ack is the one-hot ack bit
    // itself, so no gate sits between the flop and the pin
    assign WB_DAT_O               = dat_o_ff;
    assign WB_ACK_O               = bus_ff[1];
    assign RESUME_PROGRAM_COUNTER = rpc_ff;
    assign CONTROL_STATUS_WORD    = csw_ff;
    assign EXC_VIEW               = exc_view;
    assign OP_DONE                = done_ff;

endmodule : ccrop_top
`default_nettype wire

// ===== ccrop_checker.sv
// assertion checker for the compare and control register ops block
`timescale 1ns/1ns
`default_nettype none
module ccrop_checker (
    input wire logic                    CLK,
    input wire logic                    RST,
    input wire logic                    WB_CYC_I,
    input wire logic                    WB_STB_I,
    input wire logic                    WB_WE_I,
    input wire logic [7:0]              WB_ADR_I,
    input wire logic [3:0]              WB_SEL_I,
    input wire logic [31:0]             WB_DAT_I,
    input wire logic                    WB_ACK_O,
    input wire ccrop_pkg::ccrop_jump_t  JUMP_I,
    input wire ccrop_pkg::ccrop_hwcsw_t HW_CSW_I,
    input wire logic [31:0]             RESUME_PROGRAM_COUNTER,
    input wire logic [31:0]             CONTROL_STATUS_WORD,
    input wire logic [31:0]             EXC_VIEW,
    input wire logic                    OP_DONE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // the op word is executed at the edge where ack is sampled
    wire        op_wr   = WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I
                          && WB_ADR_I == ccrop_pkg::OFS_OP && WB_SEL_I == 4'hF;
    wire        csw_op  = op_wr && WB_DAT_I[1:0] == 2'h3;
    wire [31:0] csw_exc = CONTROL_STATUS_WORD & ccrop_pkg::EXC_BITS;
    logic [1:0] live_ff;
    // cycles since reset, so the delay check never sees stale history
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) live_ff <= 2'h0;
        else if (live_ff != 2'h3) live_ff <= live_ff + 2'h1;
    end
    sequence req_s; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
    sequence ack_s; WB_ACK_O ##1 !WB_ACK_O; endsequence
    ack_after_req_a: assert property (req_s |=> ack_s)
        else $error("ack not a single pulse after request");
    jump_load_a: assert property (JUMP_I.valid && !op_wr |=>
        RESUME_PROGRAM_COUNTER == $past(JUMP_I.target)) else $error("jump target lost");
    rpc_hold_a: assert property (!JUMP_I.valid && !op_wr |=>
        $stable(RESUME_PROGRAM_COUNTER)) else $error("resume pointer moved");
    hw_wins_a: assert property (HW_CSW_I.mask != 32'h0 |=>
        ((CONTROL_STATUS_WORD ^ $past(HW_CSW_I.value)) & $past(HW_CSW_I.mask)) == 32'h0)
        else $error("hardware status bits not applied");
    csw_hold_a: assert property (!csw_op && HW_CSW_I.mask == 32'h0 |=>
        $stable(CONTROL_STATUS_WORD)) else $error("status word moved");
    exc_delay_a: assert property (live_ff == 2'h3 |->
        EXC_VIEW == $past(csw_exc, 3)) else $error("exception view delay wrong");
    done_cause_a: assert property (OP_DONE |-> $past(op_wr))
        else $error("done without an operation");
    unguard_done_a: assert property (op_wr && !WB_DAT_I[4] |=> OP_DONE)
        else $error("unguarded operation not executed");
endmodule : ccrop_checker

bind ccrop_top ccrop_checker u_chk (.CLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
    .WB_SEL_I, .WB_DAT_I, .WB_ACK_O, .JUMP_I, .HW_CSW_I, .RESUME_PROGRAM_COUNTER,
    .CONTROL_STATUS_WORD, .EXC_VIEW, .OP_DONE);
`default_nettype wire

// ===== compare_and_control_register_ops_tb.sv
// self-checking bench for the compare and control register ops block
`timescale 1ns/1ns
`default_nettype none
module compare_and_control_register_ops_tb;
    logic                    clk = 1'b0;
    logic                    rst = 1'b1;
    logic                    cyc = 1'b0;
    logic                    stb = 1'b0;
    logic                    we = 1'b0;
    logic [7:0]              adr = 8'h00;
    logic [3:0]              sel = 4'hF;
    logic [31:0]             wdat = 32'h0;
    logic [31:0]             rdat, rpc, csw, excv, got;
    logic [31:0]             gval = 32'h0;
    logic                    ack, done;
    ccrop_pkg::ccrop_jump_t  jump = '0;
    ccrop_pkg::ccrop_hwcsw_t hw = '0;
    int                      err_count = 0;
    int                      check_count = 0;
    int                      exec_n = 0;

    always #4 clk = ~clk;

    ccrop_top DUT (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .JUMP_I(jump), .HW_CSW_I(hw), .RESUME_PROGRAM_COUNTER(rpc),
        .CONTROL_STATUS_WORD(csw), .EXC_VIEW(excv), .OP_DONE(done));

    // verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    // compare one word
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    // one classic cycle; core-side updates are held until it completes
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        got = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        jump.valid <= 1'b0;
        hw <= '0;
    endtask : wb

    task automatic setg(input logic [31:0] g);
        wb(1'b1, ccrop_pkg::OFS_GUARD, g);
        gval = g;
    endtask : setg

    task automatic srcs(input logic [31:0] a, input logic [31:0] b);
        wb(1'b1, ccrop_pkg::OFS_SRC1, a);
        wb(1'b1, ccrop_pkg::OFS_SRC2, b);
    endtask : srcs

    // issue an operation; done pulses only if the guard lets it run
    task automatic op(input logic [1:0] c, input logic g, input logic [6:0] imm);
        logic pass;
        pass = !g || gval[0];
        wb(1'b1, ccrop_pkg::OFS_OP, {17'h0, imm, 3'h0, g, 2'h0, c});
        @(posedge clk);
        chk({31'h0, done}, {31'h0, pass});
        if (pass) exec_n++;
    endtask : op

    task automatic cmp(input logic [31:0] a, b, input logic [1:0] c, input logic g,
                       input logic [6:0] imm, input logic [31:0] e);
        srcs(a, b);
        op(c, g, imm);
        wb(1'b0, ccrop_pkg::OFS_RESULT, 32'h0);
        chk(got, e);
    endtask : cmp

    // watchdog, far beyond the few hundred cycles the tests take
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        $display("FAIL %0t watchdog", $time);
        test_done();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        wb(1'b1, 8'h40, 32'hFFFF_FFFF);
        for (logic [7:0] a = 8'h10; a <= 8'h40; a += 8'h04) begin
            wb(1'b0, a, 32'h0);
            chk(got, 32'h0);
        end
        $display("end reset test");
        setg(32'h1);
        cmp(32'h3, 32'h4, 2'h0, 1'b0, 7'h00, 32'h1);
        cmp(32'h1000, 32'h1000, 2'h0, 1'b1, 7'h00, 32'h0);
        setg(32'hFFFF_FFFE);
        cmp(32'h1000, 32'h3, 2'h0, 1'b1, 7'h00, 32'h0);
        cmp(32'h8000_0000, 32'h4, 2'h0, 1'b0, 7'h00, 32'h1);
        cmp(32'h3, 32'h3, 2'h1, 1'b0, 7'h02, 32'h1);
        cmp(32'h3, 32'h2, 2'h1, 1'b0, 7'h03, 32'h0);
        cmp(32'h100, 32'h0, 2'h1, 1'b1, 7'h3F, 32'h0);
        cmp(32'h7F, 32'h0, 2'h1, 1'b0, 7'h7F, 32'h0);
        cmp(32'h8000_007F, 32'h0, 2'h1, 1'b0, 7'h7F, 32'h1);
        $display("end compare test");
        srcs(32'h00BE_EBEE, 32'h0);
        op(2'h2, 1'b0, 7'h00);
        chk(rpc, 32'h00BE_EBEE);
        srcs(32'h0000_ABBA, 32'h0);
        op(2'h2, 1'b1, 7'h00);
        chk(rpc, 32'h00BE_EBEE);
        setg(32'h1);
        op(2'h2, 1'b1, 7'h00);
        chk(rpc, 32'h0000_ABBA);
        jump <= {1'b1, 32'h0000_1234};
        @(posedge clk);
        jump.valid <= 1'b0;
        @(posedge clk);
        chk(rpc, 32'h0000_1234);
        srcs(32'h0000_5678, 32'h0);
        @(posedge clk);
        jump <= {1'b1, 32'h0000_9ABC};
        op(2'h2, 1'b0, 7'h00);
        chk(rpc, 32'h0000_5678);
        $display("end resume pointer test");
        srcs(32'h8011_0000, 32'hFFFF_0000);
        op(2'h3, 1'b0, 7'h00);
        chk(csw, 32'h8011_0000);
        repeat (2) @(posedge clk); // no jump before three slots pass
        chk(excv, 32'h0);
        @(posedge clk);
        chk(excv, 32'h8011_0000);
        srcs(32'h0000_0100, 32'h0000_0180); // only bits 7 and 8 are masked
        op(2'h3, 1'b0, 7'h00);
        chk(csw, 32'h8011_0100);
        setg(32'h0);
        srcs(32'h0, 32'h0000_0100);
        op(2'h3, 1'b1, 7'h00);
        chk(csw, 32'h8011_0100);
        wb(1'b0, ccrop_pkg::OFS_OP, 32'h0);
        chk(got, 32'h0000_0013);
        setg(32'h1);
        srcs(32'h0, 32'hFFFF_0000);
        op(2'h3, 1'b1, 7'h00);
        chk(csw, 32'h0000_0100);
        srcs(32'hFFFF_FFFF, 32'h0000_00FF);
        @(posedge clk);
        hw <= {32'h0000_000F, 32'h0000_0005};
        op(2'h3, 1'b0, 7'h00);
        chk(csw, 32'h0000_01F5);
        wb(1'b0, ccrop_pkg::OFS_CSW, 32'h0);
        chk(got, 32'h0000_01F5);
        wb(1'b0, ccrop_pkg::OFS_STATUS, 32'h0);
        chk(got, 32'(exec_n));
        $display("end status word test");
        test_done();
    end
endmodule : compare_and_control_register_ops_tb
`default_nettype wire
